// File: logic/gtcc_pkg.sv
// gtcc_pkg: register map, field layout, reset values and states for the guest table control.
// assumes a 32-bit classic wishbone register bus and a single 100 MHz clock.
package gtcc_pkg;
  // register byte offsets
  localparam logic [7:0] GTCC_OFF_BASE_LO = 8'h00;
  localparam logic [7:0] GTCC_OFF_BASE_HI = 8'h04;
  localparam logic [7:0] GTCC_OFF_CFG     = 8'h08;
  localparam logic [7:0] GTCC_OFF_STATUS  = 8'h0C;
  localparam logic [7:0] GTCC_OFF_IDR3    = 8'h10;
  // field positions
  localparam int GTCC_BASE_VALID_BIT = 0;
  localparam int GTCC_BASE_ADDR_LSB  = 3;
  localparam int GTCC_CFG_STRUCT_BIT = 16;
  localparam int GTCC_CFG_IDW_LSB    = 0;
  localparam int GTCC_IDW_WIDTH      = 5;
  localparam int GTCC_STAT_IDLE_BIT  = 0;
  localparam int GTCC_IDR3_LVL_BIT   = 5;
  // implementation figures
  localparam logic [4:0] GTCC_MAX_IDW    = 5'h10;
  localparam logic       GTCC_TWO_LVL_OK = 1'b1;
  localparam int         GTCC_ADDR_W     = 56;
  localparam int         GTCC_ID_W       = 16;
  localparam int         GTCC_L2_SHIFT   = 12;
  localparam int         GTCC_L1E_SHIFT  = 3;
  localparam int         GTCC_L2E_SHIFT  = 6;
  // settle cycles before a base write counts as done
  localparam logic [3:0] GTCC_SETTLE_CYC = 4'h4;
  // reset values
  localparam logic [31:0] GTCC_RST_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {GTCC_ST_IDLE, GTCC_ST_SETTLE} gtcc_state_e;
endpackage

// File: logic/gtcc_top.sv
// gtcc_top: guest table base, config, validity sequencing and walk address gate.
// assumes a classic wishbone master, one clock ref_clk, synchronous reset rst.
// What this block does
// - table is either one linear level or two levels, nothing else.
// - linear mode skips level one, the table is one level-two table.
// - base points at level two when linear, at level one when two-level.
// - in two-level mode each level-two table is 4 KB.
// - a config field selects linear or two-level structure.
// - a config field sets identifier width, sizing the indexed table.
// - guest identifiers index from 0 to two to the width minus one.
// - no memory access derives from an identifier beyond the range.
// - the range check applies to every identifier source.
// - identification field reports if two-level structure is implemented.
// - identification field reports maximum supported identifier width.
// - levels are the same on every domain and unit.
// - maximum identifier width is the same on every unit and domain.
// - base register address field holds the table base.
// - base register valid bit decides whether the table is valid.
// - base write completes only when status idle reads one.
// - table becomes valid when a zero to one valid write completes.
// - table becomes invalid when a one to zero valid write completes.
// - all units of one domain share one table.
// - no table memory access while the table is invalid.
`timescale 1ns/10ps
module gtcc_top (
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  // wishbone slave
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [7:0]                         wb_adr_i,
  input  wire logic [3:0]                         wb_sel_i,
  input  wire logic [31:0]                        wb_dat_i,
  output logic      [31:0]                        wb_dat_o,
  output logic                                    wb_ack_o,
  // walk request from any identifier source
  input  wire logic                               walk_req,
  input  wire logic [1:0]                         walk_src,
  input  wire logic [gtcc_pkg::GTCC_ID_W-1:0]     walk_id,
  // walk result toward memory
  output logic                                    mem_req_q,
  output logic      [gtcc_pkg::GTCC_ADDR_W-1:0]   mem_addr_q,
  output logic                                    mem_l1_q,
  output logic                                    walk_reject_q,
  output logic      [1:0]                         walk_src_q,
  // state shared with peer units
  output logic                                    table_valid_q,
  output logic                                    two_level_q,
  output logic      [gtcc_pkg::GTCC_ADDR_W-1:0]   table_base_q,
  output logic      [4:0]                         id_width_q
);
  typedef logic [gtcc_pkg::GTCC_ADDR_W-1:0] gtcc_addr_t;
  logic [gtcc_pkg::GTCC_ADDR_W-1:0] base_d;
  logic [31:0]                      base_lo_q;
  logic [31:0]                      base_hi_q;
  logic                             valid_req_q;
  logic                             structure_q;
  logic [4:0]                       idw_q;
  gtcc_pkg::gtcc_state_e            state_q;
  logic [3:0]                       settle_q;
  logic                             idle;
  logic                             wr_stb;
  logic                             rd_stb;
  logic                             in_range;
  logic [31:0]                      rd_data;

  // byte-lane merge used by both base register halves
  function automatic logic [31:0] gtcc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // identifier in configured range; width zero admits only id 0
  function automatic logic gtcc_id_ok(input logic [gtcc_pkg::GTCC_ID_W-1:0] id,
                                      input logic [4:0] w);
    logic [gtcc_pkg::GTCC_ID_W:0] lim;
    lim = (gtcc_pkg::GTCC_ID_W+1)'(1) << w;
    return ({1'b0, id} < lim);
  endfunction

  assign idle   = (state_q == gtcc_pkg::GTCC_ST_IDLE);
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign in_range = gtcc_id_ok(walk_id, idw_q);
  assign base_d = {base_hi_q[gtcc_pkg::GTCC_ADDR_W-33:0],
                   base_lo_q[31:gtcc_pkg::GTCC_BASE_ADDR_LSB],
                   {gtcc_pkg::GTCC_BASE_ADDR_LSB{1'b0}}};

  // one-cycle ack for every access, mapped or not
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // base register; config and base frozen while a base write settles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      base_lo_q   <= gtcc_pkg::GTCC_RST_ZERO;
      base_hi_q   <= gtcc_pkg::GTCC_RST_ZERO;
      valid_req_q <= 1'b0;
    end else if (wr_stb && idle) begin
      if (wb_adr_i == gtcc_pkg::GTCC_OFF_BASE_LO) begin
        base_lo_q   <= gtcc_merge(base_lo_q, wb_dat_i, wb_sel_i);
        if (wb_sel_i[0]) begin
          valid_req_q <= wb_dat_i[gtcc_pkg::GTCC_BASE_VALID_BIT];
        end
      end else if (wb_adr_i == gtcc_pkg::GTCC_OFF_BASE_HI) begin
        base_hi_q <= gtcc_merge(base_hi_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // config register; writes only accepted while table invalid
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      structure_q <= 1'b0;
      idw_q       <= 5'h00;
    end else if (wr_stb && idle && !table_valid_q &&
                 wb_adr_i == gtcc_pkg::GTCC_OFF_CFG) begin
      // two-level only when implemented, width clamped to maximum
      if (wb_sel_i[2]) begin
        structure_q <= wb_dat_i[gtcc_pkg::GTCC_CFG_STRUCT_BIT] &&
                       gtcc_pkg::GTCC_TWO_LVL_OK;
      end
      if (wb_sel_i[0]) begin
        idw_q <= (wb_dat_i[4:0] > gtcc_pkg::GTCC_MAX_IDW) ?
                 gtcc_pkg::GTCC_MAX_IDW : wb_dat_i[4:0];
      end
    end
  end

  // settle sequence: idle drops on any base write, returns after settle count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q  <= gtcc_pkg::GTCC_ST_IDLE;
      settle_q <= 4'h0;
    end else begin
      case (state_q)
        gtcc_pkg::GTCC_ST_IDLE: begin
          if (wr_stb && (wb_adr_i == gtcc_pkg::GTCC_OFF_BASE_LO ||
                         wb_adr_i == gtcc_pkg::GTCC_OFF_BASE_HI)) begin
            state_q  <= gtcc_pkg::GTCC_ST_SETTLE;
            settle_q <= gtcc_pkg::GTCC_SETTLE_CYC;
          end
        end
        gtcc_pkg::GTCC_ST_SETTLE: begin
          if (settle_q == 4'h1) begin
            state_q <= gtcc_pkg::GTCC_ST_IDLE;
          end
          settle_q <= settle_q - 4'h1;
        end
        default: begin
          state_q <= gtcc_pkg::GTCC_ST_IDLE;
        end
      endcase
    end
  end

  // published state changes only as the write completes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      table_valid_q <= 1'b0;
      two_level_q   <= 1'b0;
      table_base_q  <= '0;
      id_width_q    <= 5'h00;
    end else if (state_q == gtcc_pkg::GTCC_ST_SETTLE && settle_q == 4'h1) begin
      table_valid_q <= valid_req_q;
      two_level_q   <= structure_q;
      table_base_q  <= base_d;
      id_width_q    <= idw_q;
    end
  end

  // walk address generation, gated by validity and range
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_req_q     <= 1'b0;
      mem_addr_q    <= '0;
      mem_l1_q      <= 1'b0;
      walk_reject_q <= 1'b0;
      walk_src_q    <= 2'h0;
    end else begin
      mem_req_q     <= walk_req && table_valid_q && idle && in_range;
      walk_reject_q <= walk_req && !(table_valid_q && idle && in_range);
      walk_src_q    <= walk_src;
      if (walk_req) begin
        if (two_level_q) begin
          // level-one entry address; level-two table then spans one 4 KB page
          mem_addr_q <= table_base_q + (gtcc_addr_t'(walk_id >>
                        (gtcc_pkg::GTCC_L2_SHIFT - gtcc_pkg::GTCC_L2E_SHIFT))
                        << gtcc_pkg::GTCC_L1E_SHIFT);
          mem_l1_q   <= 1'b1;
        end else begin
          mem_addr_q <= table_base_q + (gtcc_addr_t'(walk_id)
                        << gtcc_pkg::GTCC_L2E_SHIFT);
          mem_l1_q   <= 1'b0;
        end
      end
    end
  end

  // register read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      gtcc_pkg::GTCC_OFF_BASE_LO: begin
        rd_data = {base_lo_q[31:1], table_valid_q};
      end
      gtcc_pkg::GTCC_OFF_BASE_HI: begin
        rd_data = base_hi_q;
      end
      gtcc_pkg::GTCC_OFF_CFG: begin
        rd_data[gtcc_pkg::GTCC_CFG_STRUCT_BIT] = structure_q;
        rd_data[4:0] = idw_q;
      end
      gtcc_pkg::GTCC_OFF_STATUS: begin
        rd_data[gtcc_pkg::GTCC_STAT_IDLE_BIT] = idle;
      end
      gtcc_pkg::GTCC_OFF_IDR3: begin
        rd_data[4:0] = gtcc_pkg::GTCC_MAX_IDW;
        rd_data[gtcc_pkg::GTCC_IDR3_LVL_BIT] = gtcc_pkg::GTCC_TWO_LVL_OK;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      wb_dat_o <= rd_data;
    end
  end

  // memory request never without valid table
  a_no_invalid_access: assert property (@(posedge ref_clk) disable iff (rst)
    mem_req_q |-> $past(table_valid_q))
    else $error("memory request while table invalid");

  // out of range identifier never reaches memory
  a_range_gate: assert property (@(posedge ref_clk) disable iff (rst)
    $past(walk_req) && !$past(in_range) |-> !mem_req_q && walk_reject_q)
    else $error("out of range identifier passed");

  // valid follows request only when settle finishes
  a_valid_on_complete: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(table_valid_q) |-> $past(state_q) == gtcc_pkg::GTCC_ST_SETTLE && idle)
    else $error("valid rose outside write completion");

  a_invalid_on_complete: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(table_valid_q) |-> $past(state_q) == gtcc_pkg::GTCC_ST_SETTLE && !valid_req_q)
    else $error("valid fell outside write completion");

  // idle returns within the settle window
  a_idle_returns: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(idle) |-> ##[1:5] idle)
    else $error("idle did not return");

  a_width_max: assert property (@(posedge ref_clk) disable iff (rst)
    idw_q <= gtcc_pkg::GTCC_MAX_IDW)
    else $error("identifier width above maximum");

  a_linear_addr: assert property (@(posedge ref_clk) disable iff (rst)
    mem_req_q && !mem_l1_q |-> !$past(two_level_q))
    else $error("linear walk used level one");

  a_two_level_ok: assert property (@(posedge ref_clk) disable iff (rst)
    mem_req_q && mem_l1_q |-> $past(two_level_q) && gtcc_pkg::GTCC_TWO_LVL_OK)
    else $error("level-one access without two-level structure");

  // bus handshake: one ack per take, read data held between reads
  a_ack_follows_take: assert property (@(posedge ref_clk) disable iff (rst)
    $past(wb_cyc_i && wb_stb_i && !wb_ack_o) |-> wb_ack_o)
    else $error("taken access not acknowledged");

  a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");

  a_ack_needs_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a bus cycle");

  a_read_data_held: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rd_stb) |-> $stable(wb_dat_o))
    else $error("read data moved without a read");

  a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o && !wb_we_i && wb_adr_i == gtcc_pkg::GTCC_OFF_STATUS |->
      wb_dat_o[gtcc_pkg::GTCC_STAT_IDLE_BIT] == $past(idle))
    else $error("status read does not show idle");

  a_ident_read: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o && !wb_we_i && wb_adr_i == gtcc_pkg::GTCC_OFF_IDR3 |->
      wb_dat_o[5:0] == {gtcc_pkg::GTCC_TWO_LVL_OK, gtcc_pkg::GTCC_MAX_IDW})
    else $error("identification read wrong");

  // settle sequence; published state moves only at completion
  a_settle_length: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(idle) |-> !idle [*4] ##1 idle)
    else $error("settle length wrong");

  a_settle_range: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == gtcc_pkg::GTCC_ST_SETTLE |-> settle_q != 4'h0 && settle_q <= gtcc_pkg::GTCC_SETTLE_CYC)
    else $error("settle count out of range");

  a_idle_count_clear: assert property (@(posedge ref_clk) disable iff (rst)
    idle |-> settle_q == 4'h0)
    else $error("settle count left over in idle");

  a_base_only_idle: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(base_lo_q) || $changed(base_hi_q) |-> $past(idle))
    else $error("base written while settling");

  a_valid_from_request: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(table_valid_q) |-> table_valid_q == $past(valid_req_q))
    else $error("valid does not follow base valid bit");

  a_base_at_end: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(table_base_q) |-> $past(state_q) == gtcc_pkg::GTCC_ST_SETTLE && idle)
    else $error("base published outside completion");

  a_level_at_end: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(two_level_q) |-> $past(state_q) == gtcc_pkg::GTCC_ST_SETTLE && idle)
    else $error("structure published outside completion");

  a_width_at_end: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(id_width_q) |-> $past(state_q) == gtcc_pkg::GTCC_ST_SETTLE && idle)
    else $error("width published outside completion");

  // configuration moves only while the table is invalid
  a_width_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(idw_q) |-> !$past(table_valid_q) && $past(idle))
    else $error("width changed while table valid");

  a_structure_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(structure_q) |-> !$past(table_valid_q) && $past(idle))
    else $error("structure changed while table valid");

  // walk answers: exactly one per request, none without one
  a_walk_one_answer: assert property (@(posedge ref_clk) disable iff (rst)
    $past(walk_req) |-> mem_req_q != walk_reject_q)
    else $error("walk not answered exactly once");

  a_walk_no_answer: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(walk_req) |-> !mem_req_q && !walk_reject_q)
    else $error("walk answer without request");

  a_walk_needs_idle: assert property (@(posedge ref_clk) disable iff (rst)
    mem_req_q |-> $past(idle))
    else $error("memory access while settling");

  a_walk_in_range: assert property (@(posedge ref_clk) disable iff (rst)
    mem_req_q |-> $past(in_range))
    else $error("memory access out of identifier range");

  a_reject_invalid: assert property (@(posedge ref_clk) disable iff (rst)
    $past(walk_req) && !$past(table_valid_q) |-> walk_reject_q)
    else $error("walk on invalid table not refused");

  a_src_echo: assert property (@(posedge ref_clk) disable iff (rst)
    $past(walk_req) |-> walk_src_q == $past(walk_src))
    else $error("source tag not echoed");

  a_linear_span: assert property (@(posedge ref_clk) disable iff (rst)
    mem_req_q && !mem_l1_q |->
      mem_addr_q - $past(table_base_q) == gtcc_addr_t'({$past(walk_id), 6'h00}))
    else $error("linear entry address wrong");

  a_l1_span: assert property (@(posedge ref_clk) disable iff (rst)
    mem_req_q && mem_l1_q |->
      mem_addr_q - $past(table_base_q) ==
        gtcc_addr_t'({$past(walk_id[gtcc_pkg::GTCC_ID_W-1:6]), 3'h0}))
    else $error("level-one entry address wrong");
endmodule

// File: tb/gtcc_mem_model.sv
// gtcc_mem_model: far-side memory stand-in that counts table accesses.
// assumes one-cycle access pulses from the guest table control.
`timescale 1ns/10ps
module gtcc_mem_model (
  // clock and reset
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  // access from the table control
  input  wire logic                             mem_req_q,
  input  wire logic [gtcc_pkg::GTCC_ADDR_W-1:0] mem_addr_q,
  input  wire logic                             mem_l1_q,
  // observed traffic
  output int                                    acc_cnt,
  output logic      [gtcc_pkg::GTCC_ADDR_W-1:0] last_addr
);
  // one image for every unit of the domain, so one counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_cnt   <= 0;
      last_addr <= '0;
    end else if (mem_req_q) begin
      acc_cnt   <= acc_cnt + 1 + int'(mem_l1_q & 1'b0);
      last_addr <= mem_addr_q;
    end
  end
endmodule

// File: tb/guest_table_config_control_tb_top.sv
// guest_table_config_control_tb_top: self-checking bench for gtcc_top.
// assumes gtcc_pkg offsets and the memory stand-in gtcc_mem_model.
`timescale 1ns/10ps
module guest_table_config_control_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic        req     = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'hF;
  logic [31:0] wdat    = 32'h0;
  logic [1:0]  src     = 2'h0;
  logic [15:0] wid     = 16'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic        ack, m_req, m_l1, rej, tv, tl;
  logic [1:0]  src_q;
  logic [55:0] m_addr, base_q, base, last;
  logic [4:0]  idw;
  int          acc_cnt;
  int          errors      = 0;
  int          checks_done = 0;
  int          n_acc       = 0;
  int          e_w         = 0;
  bit          e_two       = 0;
  bit          e_ok        = 0;
  bit          p_two       = 0;
  int          p_w         = 0;
  logic [55:0] exp_q[$];

  always #5 ref_clk = ~ref_clk;

  gtcc_top u_dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .walk_req(req), .walk_src(src), .walk_id(wid), .mem_req_q(m_req),
    .mem_addr_q(m_addr), .mem_l1_q(m_l1), .walk_reject_q(rej), .walk_src_q(src_q),
    .table_valid_q(tv), .two_level_q(tl), .table_base_q(base_q), .id_width_q(idw));
  gtcc_mem_model u_mem (.ref_clk(ref_clk), .rst(rst), .mem_req_q(m_req),
    .mem_addr_q(m_addr), .mem_l1_q(m_l1), .acc_cnt(acc_cnt), .last_addr(last));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // classic cycle; waits for ack, only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) begin
      @(posedge ref_clk);
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic walk(input logic [15:0] id);
    bit          ok;
    logic [55:0] e_addr;
    @(posedge ref_clk);
    req <= 1'b1;
    wid <= id;
    src <= 2'($urandom_range(0, 3));
    @(posedge ref_clk);
    req <= 1'b0;
    #1;
    ok = e_ok && (int'(id) < (1 << e_w));
    chk({m_req, rej}, ok ? 2'b10 : 2'b01);
    chk(src_q, src);
    if (ok) begin
      n_acc++;
      e_addr = e_two ? base + 56'(id >> 6) * 8 : base + 56'(id) * 64;
      exp_q.push_back(e_addr);
      chk(m_addr, e_addr);
      chk(m_l1, e_two);
      @(posedge ref_clk);
      #1;
      chk(last, exp_q.pop_front());
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    rdat = 32'h0;
    while (rdat[0] !== 1'b1 && n < 20) begin
      n++;
      bus(1'b0, gtcc_pkg::GTCC_OFF_STATUS, 32'h0);
    end
    chk(rdat[0], 1'b1);
  endtask

  task automatic set_base(input logic v);
    bus(1'b1, gtcc_pkg::GTCC_OFF_BASE_HI, {8'h00, base[55:32]});
    wait_idle();
    bus(1'b1, gtcc_pkg::GTCC_OFF_BASE_LO, {base[31:3], 2'b00, v});
    e_ok = 0;
    walk(16'h0001);
    if (v)
      chk(tv, 1'b0);
    wait_idle();
    chk(tv, v);
    chk(base_q, base);
    p_two = e_two;
    p_w = e_w;
    chk({tl, idw}, {p_two, 5'(p_w)});
    e_ok = v;
  endtask

  task automatic cfg(input bit two, input int w);
    bus(1'b1, gtcc_pkg::GTCC_OFF_CFG, {15'h0, two, 11'h0, 5'(w)});
    if (!e_ok) begin
      e_two = two;
      e_w = w;
    end
    bus(1'b0, gtcc_pkg::GTCC_OFF_CFG, 32'h0);
    chk(rdat, {15'h0, e_two, 11'h0, 5'(e_w)});
    chk({tl, idw}, {p_two, 5'(p_w)});
  endtask

  initial begin
    void'($urandom(80240));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    base = {24'($urandom), $urandom & 32'hFFFF_F000};
    bus(1'b0, gtcc_pkg::GTCC_OFF_IDR3, 32'h0);
    chk(rdat, 32'h0000_0030);
    bus(1'b1, 8'h14, 32'hFFFF_FFFF);
    bus(1'b0, 8'h14, 32'h0);
    chk(rdat, 32'h0);
    walk(16'h0000);
    cfg(1'b0, 4);
    set_base(1'b1);
    cfg(1'b1, 9);
    walk(16'h000F);
    walk(16'h0010);
    repeat (40) walk(16'($urandom_range(0, 31)));
    set_base(1'b0);
    walk(16'h0003);
    cfg(1'b1, 10);
    set_base(1'b1);
    walk(16'h03FF);
    walk(16'h0400);
    repeat (30) walk(16'($urandom_range(0, 1100)));
    chk(64'(acc_cnt), 64'(n_acc));
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    complete_run();
  end
endmodule
